/* File: hw/energy_pkg.sv */
/*
 * Constants, field layout and state codes of the energy-sense power
 * control block. Assumes a 20 MHz system clock.
 */
package energy_pkg;

    localparam int REG_ADDR_W = 5;
    localparam int REG_DATA_W = 16;
    localparam logic [4:0] ENERGY_SENSE_CONTROL_ADDR = 5'h1d;

    // field positions
    localparam int BIT_ALLOW = 15;
    localparam int BIT_AUTO_WAKE = 14;
    localparam int BIT_AUTO_SLEEP = 13;
    localparam int BIT_MANUAL = 12;
    localparam int BIT_SINGLE = 11;
    localparam int BIT_PWR_STATE = 10;
    localparam int BIT_ERR_HIT = 9;
    localparam int BIT_DATA_HIT = 8;
    localparam int ERR_THR_LSB = 4;
    localparam int DATA_THR_LSB = 0;
    localparam int THR_W = 4;

    // reset values
    localparam logic RST_ALLOW = 1'h0;
    localparam logic RST_AUTO_WAKE = 1'h1;
    localparam logic RST_AUTO_SLEEP = 1'h1;
    localparam logic RST_SINGLE = 1'h0;
    localparam logic [THR_W-1:0] RST_THR = 4'h1;

    // detect pulse burst
    localparam logic [2:0] BURST_PULSES = 3'h4;
    localparam logic [2:0] SINGLE_PULSES = 3'h1;
    localparam logic [3:0] PULSE_GAP_CYCLES = 4'h8;

    // quiet time before the event counters are zeroed
    localparam int unsigned QUIET_TIME_MS = 2000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned QUIET_CYCLES =
        (QUIET_TIME_MS * 32'd1_000_000) / CLK_PERIOD_NS;
    localparam int QUIET_W = 26;

    typedef enum logic [1:0]
    {
        PWR_DOWN = 2'h0,
        PWR_WAKE = 2'h1,
        PWR_UP = 2'h3,
        PWR_SLEEP = 2'h2
    } power_state_t;

    // saturating increment of an event count
    function automatic logic [THR_W-1:0] sat_inc(
        input logic [THR_W-1:0] cnt
    );
        sat_inc = (&cnt) ? cnt : cnt + 4'h1;
    endfunction

endpackage

/* File: hw/pulse_burst.sv */
/*
 * Emits a burst of energy-detect data pulses, or a single pulse.
 * Assumes i_start is a one-cycle pulse issued while the burst is idle.
 */
`timescale 1ns/1ns
module pulse_burst
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_single,
    input wire logic i_abort,
    output logic o_pulse,
    output logic o_busy
);
    import energy_pkg::*;

    logic active_ff, nxt_active;
    logic [2:0] left_ff, nxt_left;
    logic [3:0] gap_ff, nxt_gap;
    logic pulse_ff, nxt_pulse;
    logic [2:0] sent_ff, nxt_sent;
    logic [2:0] want_ff, nxt_want;

    always_comb
    begin
        nxt_active = active_ff;
        nxt_left = left_ff;
        nxt_gap = gap_ff;
        nxt_pulse = 1'h0;
        nxt_sent = sent_ff;
        nxt_want = want_ff;
        if (i_abort)
        begin
            nxt_active = 1'h0;
        end
        else if (i_start)
        begin
            nxt_active = 1'h1;
            nxt_left = i_single ? SINGLE_PULSES : BURST_PULSES;
            nxt_want = i_single ? SINGLE_PULSES : BURST_PULSES;
            nxt_gap = 4'h0;
            nxt_sent = 3'h0;
        end
        else if (active_ff && gap_ff == 4'h0)
        begin
            nxt_pulse = 1'h1;
            nxt_sent = sent_ff + 3'h1;
            nxt_left = left_ff - 3'h1;
            nxt_gap = PULSE_GAP_CYCLES;
            nxt_active = (left_ff != 3'h1);
        end
        else if (active_ff)
        begin
            nxt_gap = gap_ff - 4'h1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            active_ff <= 1'h0;
            left_ff <= 3'h0;
            gap_ff <= 4'h0;
            pulse_ff <= 1'h0;
            sent_ff <= 3'h0;
            want_ff <= 3'h0;
        end
        else
        begin
            active_ff <= nxt_active;
            left_ff <= nxt_left;
            gap_ff <= nxt_gap;
            pulse_ff <= nxt_pulse;
            sent_ff <= nxt_sent;
            want_ff <= nxt_want;
        end
    end

    assign o_pulse = pulse_ff;
    assign o_busy = active_ff | i_start;

    a_burst_length: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        $fell(active_ff) && !$past(i_abort) |-> sent_ff == want_ff)
    else $error("detect pulse count differs from selected burst length");

endmodule

/* File: hw/line_energy_power_control.sv */
/*
 * Energy-detect power control: control register, event counters,
 * power state sequencing and detect pulse launch.
 * Assumes register strobes come already decoded from the management
 * interface, and line events arrive as one-cycle pulses synchronous
 * to i_sys_clk.
 */
`timescale 1ns/1ns
module line_energy_power_control
#(
    parameter int unsigned P_QUIET_CYCLES = energy_pkg::QUIET_CYCLES
)
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [energy_pkg::REG_ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [energy_pkg::REG_DATA_W-1:0] i_reg_wdata,
    output logic [energy_pkg::REG_DATA_W-1:0] o_reg_rdata,
    input wire logic i_data_event,
    input wire logic i_error_event,
    input wire logic i_line_energy,
    output logic o_power_up,
    output logic o_energy_pulse
);
    import energy_pkg::*;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    logic wr_hit, rd_hit;
    logic allow_ff, nxt_allow;
    logic auto_wake_ff, nxt_auto_wake;
    logic auto_sleep_ff, nxt_auto_sleep;
    logic single_ff, nxt_single;
    logic [THR_W-1:0] err_thr_ff, nxt_err_thr;
    logic [THR_W-1:0] data_thr_ff, nxt_data_thr;
    logic [THR_W-1:0] data_cnt_ff, nxt_data_cnt;
    logic [THR_W-1:0] err_cnt_ff, nxt_err_cnt;
    logic [QUIET_W-1:0] quiet_ff, nxt_quiet;
    logic data_hit_ff, nxt_data_hit;
    logic err_hit_ff, nxt_err_hit;
    logic [THR_W-1:0] data_next, err_next;
    logic data_reach, err_reach, quiet_done;
    power_state_t state_ff, nxt_state;
    logic pwr_ff, nxt_pwr;
    logic man_req, burst_start, burst_abort, burst_busy;
    logic [REG_DATA_W-1:0] rdata_ff, nxt_rdata;

    assign wr_hit = i_reg_wr && (i_reg_addr == ENERGY_SENSE_CONTROL_ADDR);
    assign rd_hit = i_reg_rd && (i_reg_addr == ENERGY_SENSE_CONTROL_ADDR);

    // control fields
    always_comb
    begin
        nxt_allow = allow_ff;
        nxt_auto_wake = auto_wake_ff;
        nxt_auto_sleep = auto_sleep_ff;
        nxt_single = single_ff;
        nxt_err_thr = err_thr_ff;
        nxt_data_thr = data_thr_ff;
        if (wr_hit)
        begin
            nxt_allow = i_reg_wdata[BIT_ALLOW];
            nxt_auto_wake = i_reg_wdata[BIT_AUTO_WAKE];
            nxt_auto_sleep = i_reg_wdata[BIT_AUTO_SLEEP];
            nxt_single = i_reg_wdata[BIT_SINGLE];
            nxt_err_thr = i_reg_wdata[ERR_THR_LSB +: THR_W];
            nxt_data_thr = i_reg_wdata[DATA_THR_LSB +: THR_W];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            allow_ff <= RST_ALLOW;
            auto_wake_ff <= RST_AUTO_WAKE;
            auto_sleep_ff <= RST_AUTO_SLEEP;
            single_ff <= RST_SINGLE;
            err_thr_ff <= RST_THR;
            data_thr_ff <= RST_THR;
        end
        else
        begin
            allow_ff <= nxt_allow;
            auto_wake_ff <= nxt_auto_wake;
            auto_sleep_ff <= nxt_auto_sleep;
            single_ff <= nxt_single;
            err_thr_ff <= nxt_err_thr;
            data_thr_ff <= nxt_data_thr;
        end
    end

    // event counting against thresholds
    assign data_next = sat_inc(data_cnt_ff);
    assign err_next = sat_inc(err_cnt_ff);
    assign data_reach = allow_ff && i_data_event
        && (data_next >= data_thr_ff);
    assign err_reach = allow_ff && i_error_event
        && (err_next >= err_thr_ff);
    assign quiet_done = (quiet_ff == QUIET_W'(P_QUIET_CYCLES - 1));

    always_comb
    begin
        nxt_data_cnt = data_cnt_ff;
        nxt_err_cnt = err_cnt_ff;
        nxt_quiet = quiet_ff;
        nxt_data_hit = data_hit_ff;
        nxt_err_hit = err_hit_ff;
        if (!allow_ff)
        begin
            nxt_data_cnt = '0;
            nxt_err_cnt = '0;
            nxt_quiet = '0;
            nxt_data_hit = 1'h0;
            nxt_err_hit = 1'h0;
        end
        else
        begin
            if (i_data_event)
            begin
                nxt_data_cnt = data_next;
                nxt_quiet = '0;
            end
            else if (quiet_done)
            begin
                nxt_data_cnt = '0;
                nxt_err_cnt = '0;
                nxt_quiet = '0;
            end
            else
            begin
                nxt_quiet = quiet_ff + QUIET_W'(1);
            end
            if (i_error_event)
            begin
                nxt_err_cnt = (quiet_done && !i_data_event)
                    ? THR_W'(1) : err_next;
            end
            // read clears, a new hit in the same cycle wins
            if (rd_hit)
            begin
                nxt_data_hit = 1'h0;
                nxt_err_hit = 1'h0;
            end
            if (data_reach)
            begin
                nxt_data_hit = 1'h1;
            end
            if (err_reach)
            begin
                nxt_err_hit = 1'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            data_cnt_ff <= '0;
            err_cnt_ff <= '0;
            quiet_ff <= '0;
            data_hit_ff <= 1'h0;
            err_hit_ff <= 1'h0;
        end
        else
        begin
            data_cnt_ff <= nxt_data_cnt;
            err_cnt_ff <= nxt_err_cnt;
            quiet_ff <= nxt_quiet;
            data_hit_ff <= nxt_data_hit;
            err_hit_ff <= nxt_err_hit;
        end
    end

    // power state sequencing; error hits take no action
    assign man_req = wr_hit && i_reg_wdata[BIT_MANUAL] && allow_ff;

    always_comb
    begin
        nxt_state = state_ff;
        burst_start = 1'h0;
        if (!allow_ff)
        begin
            nxt_state = PWR_DOWN;
        end
        else
        begin
            unique case (state_ff)
                PWR_DOWN:
                begin
                    if (man_req || (auto_wake_ff && data_reach))
                    begin
                        nxt_state = PWR_WAKE;
                        burst_start = 1'h1;
                    end
                end
                PWR_WAKE:
                begin
                    if (man_req)
                    begin
                        nxt_state = PWR_SLEEP;
                    end
                    else if (!burst_busy)
                    begin
                        nxt_state = PWR_UP;
                    end
                end
                PWR_UP:
                begin
                    if (man_req || (auto_sleep_ff && !i_line_energy))
                    begin
                        nxt_state = PWR_SLEEP;
                    end
                end
                PWR_SLEEP:
                begin
                    if (man_req)
                    begin
                        nxt_state = PWR_WAKE;
                        burst_start = 1'h1;
                    end
                    else
                    begin
                        nxt_state = PWR_DOWN;
                    end
                end
            endcase
        end
        nxt_pwr = (nxt_state == PWR_WAKE) || (nxt_state == PWR_UP);
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_ff <= PWR_DOWN;
            pwr_ff <= 1'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            pwr_ff <= nxt_pwr;
        end
    end

    assign burst_abort = !allow_ff || (state_ff == PWR_WAKE && man_req);

    pulse_burst u_pulse_burst
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_start(burst_start),
        .i_single(single_ff),
        .i_abort(burst_abort),
        .o_pulse(o_energy_pulse),
        .o_busy(burst_busy)
    );

    // register read; manual bit always reads zero
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (i_reg_rd)
        begin
            nxt_rdata = '0;
            if (rd_hit)
            begin
                nxt_rdata[BIT_ALLOW] = allow_ff;
                nxt_rdata[BIT_AUTO_WAKE] = auto_wake_ff;
                nxt_rdata[BIT_AUTO_SLEEP] = auto_sleep_ff;
                nxt_rdata[BIT_SINGLE] = single_ff;
                nxt_rdata[BIT_PWR_STATE] = pwr_ff;
                nxt_rdata[BIT_ERR_HIT] = err_hit_ff;
                nxt_rdata[BIT_DATA_HIT] = data_hit_ff;
                nxt_rdata[ERR_THR_LSB +: THR_W] = err_thr_ff;
                nxt_rdata[DATA_THR_LSB +: THR_W] = data_thr_ff;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_power_up = pwr_ff;

    a_mode_off_idle: assert property (
        !allow_ff |=> state_ff == PWR_DOWN && !data_hit_ff && !err_hit_ff)
    else $error("energy logic active while mode is off");

    a_auto_wake: assert property (
        state_ff == PWR_DOWN && auto_wake_ff && data_reach
        |=> state_ff == PWR_WAKE && pwr_ff)
    else $error("no power-up after data threshold reached");

    a_auto_sleep: assert property (
        state_ff == PWR_UP && auto_sleep_ff && !i_line_energy && allow_ff
        |=> (state_ff == PWR_SLEEP && !pwr_ff)
        ##1 (state_ff == PWR_DOWN || $past(man_req)))
    else $error("no power-down on silent line");

    a_manual_toggle: assert property (
        man_req && state_ff == PWR_UP |=> state_ff == PWR_SLEEP && !pwr_ff)
    else $error("manual request did not toggle power state");

    a_state_readback: assert property (
        rd_hit |=> o_reg_rdata[BIT_PWR_STATE] == $past(pwr_ff)
        && o_reg_rdata[BIT_MANUAL] == 1'h0)
    else $error("power state bit misreported");

    a_err_flag_set: assert property (
        err_reach |=> err_hit_ff)
    else $error("error threshold flag not set");

    a_err_no_action: assert property (
        state_ff == PWR_DOWN && err_reach && !data_reach && !man_req
        |=> state_ff == PWR_DOWN)
    else $error("error threshold changed the power state");

    a_data_flag_clear: assert property (
        rd_hit && allow_ff && !data_reach |=> !data_hit_ff)
    else $error("data threshold flag not cleared by read");

    a_quiet_clear: assert property (
        allow_ff && quiet_done && !i_data_event && !i_error_event
        |=> data_cnt_ff == '0 && err_cnt_ff == '0 && quiet_ff == '0)
    else $error("event counters not zeroed after quiet time");

    a_threshold_write: assert property (
        wr_hit |=> data_thr_ff == $past(i_reg_wdata[DATA_THR_LSB +: THR_W])
        && err_thr_ff == $past(i_reg_wdata[ERR_THR_LSB +: THR_W]))
    else $error("threshold fields not written");

endmodule

/* File: dv/link_partner_model.sv */
/*
 * Behavioural remote link partner: data and error energy events and
 * the line energy level. Assumes the bench calls its tasks; outputs
 * change only at falling edges of i_sys_clk.
 */
`timescale 1ns/1ns
module link_partner_model
(
    input wire logic i_sys_clk,
    output logic o_data_event,
    output logic o_error_event,
    output logic o_line_energy
);
    initial
    begin
        o_data_event = 1'b0;
        o_error_event = 1'b0;
        o_line_energy = 1'b0;
    end

    // n back-to-back one-cycle data events
    task automatic send_data(input int n);
        repeat (n)
        begin
            @(negedge i_sys_clk);
            o_data_event = 1'b1;
        end
        @(negedge i_sys_clk);
        o_data_event = 1'b0;
    endtask

    task automatic send_error(input int n);
        repeat (n)
        begin
            @(negedge i_sys_clk);
            o_error_event = 1'b1;
        end
        @(negedge i_sys_clk);
        o_error_event = 1'b0;
    endtask

    task automatic set_energy(input logic v);
        @(negedge i_sys_clk);
        o_line_energy = v;
    endtask
endmodule

/* File: dv/tb_top.sv */
/*
 * Self-checking bench of the energy-sense power control block.
 * Assumes the design package is compiled first; quiet time shortened.
 */
`timescale 1ns/1ns
module tb_top;
    import energy_pkg::*;
    localparam int unsigned QUIET = 64;
    localparam logic [4:0] ADR = ENERGY_SENSE_CONTROL_ADDR;
    logic i_sys_clk;
    logic i_reset_n;
    logic [REG_ADDR_W-1:0] i_reg_addr;
    logic i_reg_wr;
    logic i_reg_rd;
    logic [REG_DATA_W-1:0] i_reg_wdata;
    logic [REG_DATA_W-1:0] o_reg_rdata;
    logic data_ev;
    logic err_ev;
    logic line_en;
    logic o_power_up;
    logic o_energy_pulse;
    int errors = 0;
    int total_checks = 0;
    int pulse_cnt = 0;
    // write value, expected read-back
    logic [31:0] rows [5] = '{32'h00ff_00ff, 32'h07ff_00ff,
        32'h6a5c_685c, 32'hffff_e8ff, 32'h0011_0011};

    always #25 i_sys_clk = ~i_sys_clk;

    always @(negedge i_sys_clk)
        if (o_energy_pulse === 1'b1)
            pulse_cnt++;

    line_energy_power_control #(.P_QUIET_CYCLES(QUIET)) uut
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .i_data_event(data_ev),
        .i_error_event(err_ev),
        .i_line_energy(line_en),
        .o_power_up(o_power_up),
        .o_energy_pulse(o_energy_pulse)
    );

    link_partner_model link
    (
        .i_sys_clk(i_sys_clk),
        .o_data_event(data_ev),
        .o_error_event(err_ev),
        .o_line_energy(line_en)
    );

    task automatic stop_test();
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [REG_DATA_W-1:0] d);
        @(negedge i_sys_clk);
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_sys_clk);
        i_reg_wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [REG_ADDR_W-1:0] a,
        input logic [REG_DATA_W-1:0] exp);
        @(negedge i_sys_clk);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_sys_clk);
        i_reg_rd = 1'b0;
        i_reg_addr = ADR;
        chk(o_reg_rdata, exp);
    endtask

    task automatic chk_pwr(input logic v);
        chk({15'h0000, o_power_up}, {15'h0000, v});
    endtask

    // bounded wait for the power state, fatal to the run on timeout
    task automatic wait_pwr(input logic v, input int n);
        int k;
        k = 0;
        while (o_power_up !== v && k < n)
        begin
            @(negedge i_sys_clk);
            k++;
        end
        chk_pwr(v);
        if (o_power_up !== v)
            stop_test();
    endtask

    initial
    begin
        i_sys_clk = 1'h0;
        i_reset_n = 1'h0;
        i_reg_addr = ADR;
        i_reg_wr = 1'h0;
        i_reg_rd = 1'h0;
        i_reg_wdata = 16'h0000;
        repeat (3) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        reg_rd(ADR, 16'h6011);
        reg_rd(5'h1c, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            reg_wr(rows[i][31:16]);
            reg_rd(ADR, rows[i][15:0]);
        end
        // write to an unmapped address leaves the register alone
        @(negedge i_sys_clk);
        i_reg_addr = 5'h1c;
        reg_wr(16'hffff);
        i_reg_addr = ADR;
        reg_rd(ADR, 16'h0011);
        reg_wr(16'h7011);
        link.send_data(1);
        chk_pwr(1'b0);
        reg_rd(ADR, 16'h6011);
        // automatic wake with a full burst; negotiation taken as on
        reg_wr(16'he011);
        link.set_energy(1'b1);
        pulse_cnt = 0;
        link.send_data(1);
        chk_pwr(1'b1);
        repeat (40) @(negedge i_sys_clk);
        chk(pulse_cnt[15:0], 16'h0004);
        reg_rd(ADR, 16'he511);
        reg_rd(ADR, 16'he411);
        link.set_energy(1'b0);
        wait_pwr(1'b0, 4);
        reg_rd(ADR, 16'he011);
        // single pulse on wake
        reg_wr(16'he811);
        link.set_energy(1'b1);
        pulse_cnt = 0;
        link.send_data(1);
        chk_pwr(1'b1);
        repeat (40) @(negedge i_sys_clk);
        chk(pulse_cnt[15:0], 16'h0001);
        link.set_energy(1'b0);
        wait_pwr(1'b0, 4);
        reg_rd(ADR, 16'he911);
        // manual toggle both ways, automatic control off
        reg_wr(16'h9011);
        wait_pwr(1'b1, 3);
        reg_wr(16'h9011);
        wait_pwr(1'b0, 3);
        // manual wake runs the full burst, then manual sleep from up
        pulse_cnt = 0;
        reg_wr(16'h9011);
        wait_pwr(1'h1, 3);
        repeat (40) @(negedge i_sys_clk);
        chk(pulse_cnt[15:0], 16'h0004);
        reg_wr(16'h9011);
        wait_pwr(1'h0, 3);
        // error threshold of two, counters cleared first
        reg_wr(16'h0000);
        reg_wr(16'h8021);
        link.send_error(1);
        reg_rd(ADR, 16'h8021);
        link.send_error(1);
        reg_rd(ADR, 16'h8221);
        reg_rd(ADR, 16'h8021);
        chk_pwr(1'b0);
        // quiet time zeroes the data count
        reg_wr(16'h0000);
        reg_wr(16'h8003);
        link.send_data(2);
        reg_rd(ADR, 16'h8003);
        repeat (QUIET + 8) @(negedge i_sys_clk);
        link.send_data(1);
        reg_rd(ADR, 16'h8003);
        link.send_data(2);
        reg_rd(ADR, 16'h8103);
        // reset in mid-run
        @(negedge i_sys_clk);
        i_reset_n = 1'b0;
        @(negedge i_sys_clk);
        chk_pwr(1'b0);
        chk(o_reg_rdata, 16'h0000);
        i_reset_n = 1'b1;
        reg_rd(ADR, 16'h6011);
        stop_test();
    end
endmodule
